// *** cpr_pkg.sv ***
// shared constants of the content protection register ports
package cpr_pkg;

	// ************************************************************
	// widths
	// ************************************************************
	localparam int PROT_AW = 8;
	localparam int PROT_DW = 8;
	localparam int MSG_AW = 8;
	localparam int MSG_DW = 32;
	localparam int MSG_BYTE_AW = 10;
	localparam int MSG_WORDS_DEF = 32;

	// ************************************************************
	// protection register offsets
	// ************************************************************
	localparam logic [7:0] PROT_CTRL = 8'h00;
	localparam logic [7:0] PROT_STATUS = 8'h01;
	localparam logic [7:0] PROT_KEY_ADDR = 8'h02;
	localparam logic [7:0] PROT_STOP_CNT = 8'h03;
	localparam logic [7:0] PROT_KEY_BYTE0 = 8'h04;
	localparam logic [7:0] PROT_KEY_BYTE3 = 8'h07;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int CTRL_KEY_START = 0;
	localparam int CTRL_STOP_CLR = 1;
	localparam int STAT_KEY_BUSY = 0;
	localparam int STAT_KEY_DONE = 1;
	localparam int STAT_MSG_VALID = 2;
	localparam int STAT_KEY_WAIT = 3;
	localparam int MSG_CTRL_DONE = 0;

	// ************************************************************
	// message word indexes
	// ************************************************************
	localparam logic [7:0] MSG_TOPO_IDX = 8'h00;
	localparam logic [7:0] MSG_CTRL_IDX = 8'hff;

	// ************************************************************
	// reset values and timing
	// ************************************************************
	localparam logic [7:0] KEY_ADDR_RST = 8'h00;
	localparam logic [7:0] STOP_CNT_RST = 8'h00;
	localparam logic [1:0] KEY_SETTLE = 2'h3;

endpackage : cpr_pkg

// *** cpr_if.sv ***
// interface joining the protection device end and its masters
`timescale 1ns/100ps
interface cpr_if;
	import cpr_pkg::*;

	logic [PROT_AW-1:0] protAddr;
	logic protWr;
	logic protRd;
	logic [PROT_DW-1:0] protWrData;
	logic [PROT_DW-1:0] protRdData;
	logic stopDet;
	logic [MSG_AW-1:0] msgAddr;
	logic msgWr;
	logic msgRd;
	logic [MSG_DW-1:0] msgWrData;
	logic [MSG_DW-1:0] msgRdData;

	modport dev (
		input protAddr, protWr, protRd, protWrData, stopDet,
		input msgAddr, msgWr, msgRd, msgWrData,
		output protRdData, msgRdData
	);

	modport host (
		output protAddr, protWr, protRd, protWrData, stopDet,
		output msgAddr, msgWr, msgRd, msgWrData,
		input protRdData, msgRdData
	);

endinterface : cpr_if

// *** cpr_sync2.sv ***
// two flip-flop synchroniser for a level from outside the clock domain
`timescale 1ns/100ps
module cpr_sync2 (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic asyncIn,
	output logic syncOut
);
	// ************************************************************
	// first stage feeds only the second
	// ************************************************************
	typedef struct packed {
		logic meta;
		logic sync;
	} cpr_sync_st_t;

	cpr_sync_st_t st_r;
	cpr_sync_st_t st_nxt;

	// pin into the first stage, first stage into the second
	always_comb begin
		st_nxt.meta = asyncIn;
		st_nxt.sync = st_r.meta;
	end

	// both stages registered together
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// output straight from the second stage
	assign syncOut = st_r.sync;

endmodule // cpr_sync2

// *** cpr_device.sv ***
// device end: protection register port, repeater message port, key fetch
`timescale 1ns/100ps
module cpr_device #(
	parameter int MSG_WORDS = cpr_pkg::MSG_WORDS_DEF,
	parameter bit REPEATER_EN = 1'b1
) (
	input wire logic clk,
	input wire logic sys_rst,
	cpr_if.dev link,
	input wire logic keyWaitPin,
	input wire logic [cpr_pkg::MSG_DW-1:0] keyData,
	output logic [cpr_pkg::PROT_AW-1:0] keyRdAddr,
	output logic keyRdReq,
	output logic [cpr_pkg::MSG_DW-1:0] keyWord,
	output logic keyWordValid,
	output logic msgValid,
	input wire logic msgTaken,
	output logic [cpr_pkg::MSG_DW-1:0] topologyWord,
	input wire logic [cpr_pkg::MSG_AW-1:0] idIndex,
	output logic [cpr_pkg::MSG_DW-1:0] idWord,
	output logic [cpr_pkg::PROT_DW-1:0] stopCount
);
	import cpr_pkg::*;

	// ************************************************************
	// elaboration checks
	// ************************************************************
	localparam int IW = (MSG_WORDS > 1) ? $clog2(MSG_WORDS) : 1;

	if (MSG_WORDS < 2 || MSG_WORDS > 255) begin : gBadDepth
		$error("MSG_WORDS must lie between 2 and 255");
	end

	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		logic [PROT_DW-1:0] protRdData;
		logic [MSG_DW-1:0] msgRdData;
		logic [PROT_AW-1:0] keyAddr;
		logic [PROT_DW-1:0] stopCnt;
		logic keyBusy;
		logic keyDone;
		logic [1:0] settle;
		logic [MSG_DW-1:0] keyWord;
		logic keyWordValid;
		logic msgValid;
		logic [MSG_WORDS-1:0][MSG_DW-1:0] msgMem;
		logic [MSG_DW-1:0] idWord;
	} cpr_dev_st_t;

	cpr_dev_st_t st_r;
	cpr_dev_st_t st_nxt;
	logic keyWait;

	// ************************************************************
	// key wait comes from the key store pin
	// ************************************************************
	cpr_sync2 uKeyWaitSync (
		.clk(clk),
		.sys_rst(sys_rst),
		.asyncIn(keyWaitPin),
		.syncOut(keyWait)
	);

	// ************************************************************
	// helpers
	// ************************************************************
	// byte lane of a 32-bit word
	function automatic logic [7:0] laneOf(input logic [31:0] w, input logic [1:0] lane);
		logic [7:0] b;
		b = w[8*lane +: 8];
		return b;
	endfunction

	// word index inside the message store
	function automatic logic inStore(input logic [MSG_AW-1:0] idx);
		logic ok;
		ok = (int'(idx) < MSG_WORDS);
		return ok;
	endfunction

	// status byte
	function automatic logic [7:0] statusByte(input cpr_dev_st_t s, input logic w);
		logic [7:0] b;
		b = 8'h00;
		b[STAT_KEY_BUSY] = s.keyBusy;
		b[STAT_KEY_DONE] = s.keyDone;
		b[STAT_MSG_VALID] = s.msgValid;
		b[STAT_KEY_WAIT] = w;
		return b;
	endfunction

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		st_nxt = st_r;
		st_nxt.keyWordValid = 1'b0;

		// byte port writes, zero wait
		if (link.protWr) begin
			unique case (link.protAddr)
				PROT_CTRL: begin
					if (link.protWrData[CTRL_KEY_START] && !st_r.keyBusy) begin
						st_nxt.keyBusy = 1'b1;
						st_nxt.keyDone = 1'b0;
						st_nxt.settle = KEY_SETTLE;
					end
					if (link.protWrData[CTRL_STOP_CLR]) begin
						st_nxt.stopCnt = STOP_CNT_RST;
					end
				end
				PROT_KEY_ADDR: st_nxt.keyAddr = link.protWrData;
				default: ;
			endcase
		end

		// byte port reads, answered on the next edge
		if (link.protRd) begin
			if (link.protAddr == PROT_CTRL) begin
				st_nxt.protRdData = 8'h00;
			end else if (link.protAddr == PROT_STATUS) begin
				st_nxt.protRdData = statusByte(st_r, keyWait);
			end else if (link.protAddr == PROT_KEY_ADDR) begin
				st_nxt.protRdData = st_r.keyAddr;
			end else if (link.protAddr == PROT_STOP_CNT) begin
				st_nxt.protRdData = st_r.stopCnt;
			end else if (link.protAddr >= PROT_KEY_BYTE0 && link.protAddr <= PROT_KEY_BYTE3) begin
				st_nxt.protRdData = laneOf(st_r.keyWord, link.protAddr[1:0]);
			end else begin
				st_nxt.protRdData = 8'h00;
			end
		end

		// stop condition counted; it wins over a clear in the same cycle
		if (link.stopDet) begin
			st_nxt.stopCnt = st_r.stopCnt + 8'h01;
		end

		// key fetch: settle, then take data only once wait has dropped
		if (st_r.keyBusy) begin
			if (st_r.settle != 2'h0) begin
				st_nxt.settle = st_r.settle - 2'h1;
			end else if (!keyWait) begin
				st_nxt.keyWord = keyData;
				st_nxt.keyBusy = 1'b0;
				st_nxt.keyDone = 1'b1;
				st_nxt.keyWordValid = 1'b1;
			end
		end

		// message port, present only with repeater support
		if (REPEATER_EN) begin
			// consumer hand-back clears the burst flag
			if (msgTaken) begin
				st_nxt.msgValid = 1'b0;
			end
			// writes complete in the strobe cycle
			if (link.msgWr) begin
				if (inStore(link.msgAddr)) begin
					st_nxt.msgMem[link.msgAddr[IW-1:0]] = link.msgWrData;
				end else if (link.msgAddr == MSG_CTRL_IDX && link.msgWrData[MSG_CTRL_DONE]) begin
					st_nxt.msgValid = 1'b1;
				end
			end
			// reads return on the next edge
			if (link.msgRd) begin
				if (inStore(link.msgAddr)) begin
					st_nxt.msgRdData = st_r.msgMem[link.msgAddr[IW-1:0]];
				end else if (link.msgAddr == MSG_CTRL_IDX) begin
					st_nxt.msgRdData = {31'h00000000, st_r.msgValid};
				end else begin
					st_nxt.msgRdData = 32'h00000000;
				end
			end
		end

		// local read of the identifier list
		if (inStore(idIndex)) begin
			st_nxt.idWord = st_r.msgMem[idIndex[IW-1:0]];
		end else begin
			st_nxt.idWord = 32'h00000000;
		end
	end

	// ************************************************************
	// registers, one step per clock
	// ************************************************************
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_r <= '0;
			st_r.keyAddr <= KEY_ADDR_RST;
			st_r.stopCnt <= STOP_CNT_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ************************************************************
	// outputs straight from flops
	// ************************************************************
	assign link.protRdData = st_r.protRdData;
	assign link.msgRdData = st_r.msgRdData;
	assign keyRdAddr = st_r.keyAddr;
	assign keyRdReq = st_r.keyBusy;
	assign keyWord = st_r.keyWord;
	assign keyWordValid = st_r.keyWordValid;
	assign msgValid = st_r.msgValid;
	assign topologyWord = st_r.msgMem[MSG_TOPO_IDX[IW-1:0]];
	assign idWord = st_r.idWord;
	assign stopCount = st_r.stopCnt;

endmodule // cpr_device

// *** cpr_host.sv ***
// host end: two-wire slave side and message processor side masters
`timescale 1ns/100ps
module cpr_host (
	input wire logic clk,
	input wire logic sys_rst,
	cpr_if.host link,
	input wire logic protReqWr,
	input wire logic protReqRd,
	input wire logic [cpr_pkg::PROT_AW-1:0] protReqAddr,
	input wire logic [cpr_pkg::PROT_DW-1:0] protReqData,
	input wire logic protReqStop,
	output logic protRspValid,
	output logic [cpr_pkg::PROT_DW-1:0] protRspData,
	input wire logic msgReqWr,
	input wire logic msgReqRd,
	input wire logic [cpr_pkg::MSG_BYTE_AW-1:0] msgReqByteAddr,
	input wire logic [cpr_pkg::MSG_DW-1:0] msgReqData,
	output logic msgRspValid,
	output logic [cpr_pkg::MSG_DW-1:0] msgRspData
);
	import cpr_pkg::*;

	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		logic [PROT_AW-1:0] protAddr;
		logic protWr;
		logic protRd;
		logic [PROT_DW-1:0] protWrData;
		logic stopDet;
		logic protPend;
		logic protRspValid;
		logic [PROT_DW-1:0] protRspData;
		logic [MSG_AW-1:0] msgAddr;
		logic msgWr;
		logic msgRd;
		logic [MSG_DW-1:0] msgWrData;
		logic msgPend;
		logic msgRspValid;
		logic [MSG_DW-1:0] msgRspData;
	} cpr_host_st_t;

	cpr_host_st_t st_r;
	cpr_host_st_t st_nxt;

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		st_nxt = st_r;
		// byte port strobes, driven one cycle after the request
		st_nxt.protWr = protReqWr;
		st_nxt.protRd = protReqRd && !protReqWr;
		if (protReqWr || protReqRd) begin
			st_nxt.protAddr = protReqAddr;
			st_nxt.protWrData = protReqData;
		end
		st_nxt.stopDet = protReqStop;
		// capture read data the cycle after the strobe
		st_nxt.protPend = st_r.protRd;
		st_nxt.protRspValid = st_r.protPend;
		if (st_r.protPend) begin
			st_nxt.protRspData = link.protRdData;
		end
		// message port, byte address to word address
		st_nxt.msgWr = msgReqWr;
		st_nxt.msgRd = msgReqRd && !msgReqWr;
		if (msgReqWr || msgReqRd) begin
			st_nxt.msgAddr = msgReqByteAddr[MSG_BYTE_AW-1:2];
			st_nxt.msgWrData = msgReqData;
		end
		st_nxt.msgPend = st_r.msgRd;
		st_nxt.msgRspValid = st_r.msgPend;
		if (st_r.msgPend) begin
			st_nxt.msgRspData = link.msgRdData;
		end
	end

	// ************************************************************
	// registers
	// ************************************************************
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ************************************************************
	// outputs straight from flops
	// ************************************************************
	assign link.protAddr = st_r.protAddr;
	assign link.protWr = st_r.protWr;
	assign link.protRd = st_r.protRd;
	assign link.protWrData = st_r.protWrData;
	assign link.stopDet = st_r.stopDet;
	assign link.msgAddr = st_r.msgAddr;
	assign link.msgWr = st_r.msgWr;
	assign link.msgRd = st_r.msgRd;
	assign link.msgWrData = st_r.msgWrData;
	assign protRspValid = st_r.protRspValid;
	assign protRspData = st_r.protRspData;
	assign msgRspValid = st_r.msgRspValid;
	assign msgRspData = st_r.msgRspData;

endmodule // cpr_host

// *** cpr_if_chk.sv ***
// assertions on the link between the device end and the host end
`timescale 1ns/100ps
module cpr_if_chk #(
	parameter int MSG_WORDS = cpr_pkg::MSG_WORDS_DEF
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [cpr_pkg::PROT_AW-1:0] protAddr,
	input wire logic protWr,
	input wire logic protRd,
	input wire logic [cpr_pkg::PROT_DW-1:0] protWrData,
	input wire logic [cpr_pkg::PROT_DW-1:0] protRdData,
	input wire logic stopDet,
	input wire logic [cpr_pkg::MSG_AW-1:0] msgAddr,
	input wire logic msgWr,
	input wire logic msgRd,
	input wire logic [cpr_pkg::MSG_DW-1:0] msgWrData,
	input wire logic [cpr_pkg::MSG_DW-1:0] msgRdData
);
	import cpr_pkg::*;
	// ************
	// properties
	// ************
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	AST_PROT_HOLD: assert property (!$past(protRd) |-> $stable(protRdData))
		else $error("byte read data moved without a read");
	AST_KEYADDR_RB: assert property (protWr && protAddr == PROT_KEY_ADDR
		##1 protRd && !protWr && protAddr == PROT_KEY_ADDR
		|=> protRdData == $past(protWrData, 2))
		else $error("key address readback wrong");
	AST_CTRL_RD0: assert property (protRd && protAddr == PROT_CTRL |=> protRdData == '0)
		else $error("control read not zero");
	AST_UNMAPPED: assert property (protRd && protAddr > PROT_KEY_BYTE3 |=> protRdData == '0)
		else $error("unmapped byte read not zero");
	AST_STROBE_EXCL: assert property (!(protWr && protRd))
		else $error("byte write and read together");
	AST_STOP_PULSE: assert property ($rose(stopDet) |=> !stopDet)
		else $error("stop pulse too long");
	AST_MSG_HOLD: assert property (!$past(msgRd) |-> $stable(msgRdData))
		else $error("message read data moved without a read");
	AST_MSG_WRRD: assert property (msgWr && msgAddr < MSG_WORDS
		##1 msgRd && !msgWr && $stable(msgAddr)
		|=> msgRdData == $past(msgWrData, 2))
		else $error("message write not seen by next read");
	AST_MSG_OOR: assert property (msgRd && msgAddr >= MSG_WORDS
		&& msgAddr != 8'hff |=> msgRdData == '0)
		else $error("out of range message read not zero");
	// main scenarios
	cover property (msgWr ##1 msgRd);
	cover property (msgWr && msgAddr == MSG_CTRL_IDX);
	cover property (protWr ##1 protRd);
	cover property (stopDet);
endmodule // cpr_if_chk

// *** tb.sv ***
// self-checking bench joining the host end to the device end
`timescale 1ns/100ps
module tb;
	import cpr_pkg::*;
	localparam int MW = 8;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic keyWaitPin = 1'b1;
	logic [31:0] keyData = '0;
	logic msgTaken = 1'b0;
	logic [7:0] idIndex = '0;
	logic protReqWr = 1'b0, protReqRd = 1'b0, protReqStop = 1'b0;
	logic [7:0] protReqAddr = '0, protReqData = '0;
	logic msgReqWr = 1'b0, msgReqRd = 1'b0;
	logic [9:0] msgReqByteAddr = '0;
	logic [31:0] msgReqData = '0;
	logic keyRdReq, keyWordValid, msgValid, protRspValid, msgRspValid;
	logic [7:0] keyRdAddr, stopCount, protRspData;
	logic [31:0] keyWord, topologyWord, idWord, msgRspData;
	int errors = 0;
	int checks_done = 0;
	// ************
	// ends and checker
	// ************
	cpr_if cpr_if_inst();
	cpr_device #(.MSG_WORDS(MW)) cpr_device_inst (.clk, .sys_rst, .link(cpr_if_inst),
		.keyWaitPin, .keyData, .keyRdAddr, .keyRdReq, .keyWord, .keyWordValid, .msgValid,
		.msgTaken, .topologyWord, .idIndex, .idWord, .stopCount);
	cpr_host cpr_host_inst (.clk, .sys_rst, .link(cpr_if_inst), .protReqWr, .protReqRd,
		.protReqAddr, .protReqData, .protReqStop, .protRspValid, .protRspData, .msgReqWr,
		.msgReqRd, .msgReqByteAddr, .msgReqData, .msgRspValid, .msgRspData);
	cpr_if_chk #(.MSG_WORDS(MW)) cpr_if_chk_inst (.clk, .sys_rst,
		.protAddr(cpr_if_inst.protAddr), .protWr(cpr_if_inst.protWr),
		.protRd(cpr_if_inst.protRd), .protWrData(cpr_if_inst.protWrData),
		.protRdData(cpr_if_inst.protRdData), .stopDet(cpr_if_inst.stopDet),
		.msgAddr(cpr_if_inst.msgAddr), .msgWr(cpr_if_inst.msgWr), .msgRd(cpr_if_inst.msgRd),
		.msgWrData(cpr_if_inst.msgWrData), .msgRdData(cpr_if_inst.msgRdData));
	// clock
	initial begin
		forever #12.5 clk = ~clk;
	end
	// ************
	// tasks
	// ************
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			$display("unexpected %s: expected %h seen %h", n, e, g);
			errors++;
		end
	endtask
	task automatic tick();
		@(posedge clk);
		#1;
	endtask
	// one request cycle on each user side, held until the next edge
	task automatic pOp(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
		tick();
		protReqWr = w;
		protReqRd = r;
		protReqAddr = a;
		protReqData = d;
	endtask
	task automatic mOp(input logic w, input logic r, input logic [9:0] a, input logic [31:0] d);
		tick();
		msgReqWr = w;
		msgReqRd = r;
		msgReqByteAddr = a;
		msgReqData = d;
	endtask
	// read and wait a bounded time for the answer pulse
	task automatic pRead(input logic [7:0] a, input logic [7:0] e);
		int i;
		pOp(1'b0, 1'b1, a, 8'h00);
		pOp(1'b0, 1'b0, a, 8'h00);
		for (i = 0; i < 6 && protRspValid !== 1'b1; i++) tick();
		chk("byte answer", 32'h1, 32'(protRspValid));
		chk("byte data", 32'(e), 32'(protRspData));
	endtask
	task automatic mRead(input logic [9:0] a, input logic [31:0] e);
		int i;
		mOp(1'b0, 1'b1, a, '0);
		mOp(1'b0, 1'b0, a, '0);
		for (i = 0; i < 6 && msgRspValid !== 1'b1; i++) tick();
		chk("word answer", 32'h1, 32'(msgRspValid));
		chk("word data", e, msgRspData);
	endtask
	task automatic give_verdict();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// ************
	// tests
	// ************
	initial begin
		int i;
		repeat (4) @(posedge clk);
		#1 sys_rst = 1'b0;
		pRead(PROT_STOP_CNT, STOP_CNT_RST);
		pOp(1'b1, 1'b0, PROT_KEY_ADDR, 8'ha5);
		pRead(PROT_KEY_ADDR, 8'ha5);
		chk("key address", 32'ha5, 32'(keyRdAddr));
		pRead(PROT_CTRL, 8'h00);
		pRead(8'h40, 8'h00);
		for (i = 0; i < 3; i++) begin
			tick();
			protReqStop = 1'b1;
			tick();
			protReqStop = 1'b0;
		end
		pRead(PROT_STOP_CNT, 8'h03);
		chk("stop count", 32'h3, 32'(stopCount));
		pOp(1'b1, 1'b0, PROT_CTRL, 8'h02);
		pRead(PROT_STOP_CNT, 8'h00);
		for (i = 0; i < MW; i++) mOp(1'b1, 1'b0, 10'(i * 4), 32'hc0de0000 + i);
		mRead(10'h008, 32'hc0de0002);
		mRead(10'h007, 32'hc0de0001);
		mOp(1'b1, 1'b0, 10'(MW * 4), 32'hdead);
		mRead(10'(MW * 4), 32'h0);
		mOp(1'b1, 1'b0, 10'h00c, 32'h12345678);
		mRead(10'h00c, 32'h12345678);
		chk("topology", 32'hc0de0000, topologyWord);
		idIndex = 8'h03;
		tick();
		tick();
		chk("id word", 32'h12345678, idWord);
		mOp(1'b1, 1'b0, 10'h3fc, 32'h1);
		mRead(10'h3fc, 32'h1);
		pRead(PROT_STATUS, 8'h0c);
		msgTaken = 1'b1;
		tick();
		msgTaken = 1'b0;
		chk("burst flag", 32'h0, 32'(msgValid));
		keyData = 32'hbad0bad0;
		pOp(1'b1, 1'b0, PROT_CTRL, 8'h01);
		pOp(1'b0, 1'b0, PROT_CTRL, 8'h00);
		repeat (8) tick();
		chk("fetch busy", 32'h1, 32'(keyRdReq));
		chk("key held", 32'h0, keyWord);
		keyData = 32'h89abcdef;
		keyWaitPin = 1'b0;
		for (i = 0; i < 10 && keyWordValid !== 1'b1; i++) tick();
		chk("key valid", 32'h1, 32'(keyWordValid));
		chk("key word", 32'h89abcdef, keyWord);
		pRead(PROT_KEY_BYTE0, 8'hef);
		pRead(PROT_KEY_BYTE3, 8'h89);
		// raise the burst flag again so that the reset has something to clear
		mOp(1'b1, 1'b0, 10'h3fc, 32'h1);
		mOp(1'b0, 1'b0, 10'h3fc, 32'h0);
		tick();
		chk("burst flag set", 32'h1, 32'(msgValid));
		sys_rst = 1'b1;
		repeat (3) tick();
		sys_rst = 1'b0;
		chk("key word reset", 32'h0, keyWord);
		pRead(PROT_KEY_ADDR, KEY_ADDR_RST);
		chk("burst flag reset", 32'h0, 32'(msgValid));
		give_verdict();
	end
	// watchdog against a hang
	initial begin
		#(25 * 3000);
		errors++;
		give_verdict();
	end
endmodule // tb
